// ---- dv/ucg_clock_gen_asserts.sv ----
// Port checker for the clock generator
`default_nettype none
module ucg_clock_gen_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic tx_active_i,
  input wire logic transfer_clock_pin_i,
  input wire logic transfer_clock_pin_oe_n_o,
  input wire logic line_driver_enable_o,
  input wire logic sample_tick_o,
  input wire logic bit_tick_o,
  input wire ucg_pkg::ucg_mode_t mode_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic slv = mode_o == ucg_pkg::UCG_SYNC_SLAVE;
  wire logic mst = mode_o == ucg_pkg::UCG_SYNC_MASTER;
  ////////////////////////////////////////////////////////////////////////////////
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack one cycle after request");
  unmapped_zero_a: assert property (wb_ack_o && !(wb_adr_i inside {8'h00, 8'h04, 8'h08})
    |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  bit_sample_a: assert property (bit_tick_o |-> sample_tick_o)
    else $error("bit tick without sample tick");
  driver_idle_a: assert property (!$past(tx_active_i) |-> !line_driver_enable_o)
    else $error("line driver on while idle");
  double_space_a: assert property (bit_tick_o && mode_o == ucg_pkg::UCG_ASYNC_DOUBLE
    |=> (!bit_tick_o || mode_o != ucg_pkg::UCG_ASYNC_DOUBLE) [*7])
    else $error("double speed bit too short");
  sync_space_a: assert property (bit_tick_o && mst |=> !bit_tick_o || !mst)
    else $error("sync bit shorter than two samples");
  slave_release_a: assert property (slv && $past(slv) |-> transfer_clock_pin_oe_n_o)
    else $error("clock pin driven in slave mode");
  master_drive_a: assert property (mst && $past(mst) |-> !transfer_clock_pin_oe_n_o)
    else $error("clock pin not driven in master mode");
  slave_tick_a: assert property (slv && $rose(transfer_clock_pin_i) |-> ##[2:6] bit_tick_o)
    else $error("no bit tick after external clock rise");
  cover property (bit_tick_o && mode_o == ucg_pkg::UCG_ASYNC_DOUBLE);
  cover property (slv && bit_tick_o);
  cover property (wb_ack_o && wb_adr_i == 8'h0C);
endmodule
bind ucg_clock_gen ucg_clock_gen_asserts i_ucg_clock_gen_asserts (.clk_i, .rst_i, .wb_cyc_i,
  .wb_stb_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .tx_active_i, .transfer_clock_pin_i,
  .transfer_clock_pin_oe_n_o, .line_driver_enable_o, .sample_tick_o, .bit_tick_o, .mode_o);
`default_nettype wire

// ---- dv/ucg_clock_gen_bench.sv ----
// Self-checking bench for the clock generator
`default_nettype none
module ucg_clock_gen_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, halt = 0, txd = 0, txa = 0, start = 0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, q, sc, bc, tc;
  logic ack, xck_o, xck_oe_n, dat_o, dat_oe_n, lde, stk, btk, node_xck;
  wire logic xck_w = xck_oe_n ? node_xck : xck_o;
  ucg_pkg::ucg_mode_t mode;
  int err_total = 0, samples_checked = 0;
  // div, ctrl, window, samples, bits, pin toggles
  logic [55:0] tbl [6] = '{56'h0040_00_40_40_04_00, 56'h0060_00_60_40_04_00,
    56'h0040_04_40_40_08_00, 56'h0040_02_40_40_04_00, 56'h00BF_11_40_20_10_20,
    56'h00BF_03_40_20_10_20};
  ucg_clock_gen i_ucg_clock_gen (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .debug_halt_i(halt), .tx_data_i(txd), .tx_active_i(txa), .transfer_clock_pin_i(xck_w),
    .transfer_clock_pin_o(xck_o), .transfer_clock_pin_oe_n_o(xck_oe_n), .data_pin_o(dat_o),
    .data_pin_oe_n_o(dat_oe_n), .line_driver_enable_o(lde), .sample_tick_o(stk),
    .bit_tick_o(btk), .mode_o(mode));
  ucg_remote_node i_ucg_remote_node (.clk_i, .rst_i, .start_i(start), .xck_o(node_xck));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    if (err_total == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  // Counts ticks and pin toggles once per cycle, at the settled half
  task automatic win(input logic [7:0] n);
    logic p;
    @(negedge clk_i);
    p = xck_o;
    sc = 32'h0;
    bc = 32'h0;
    tc = 32'h0;
    repeat (n) begin
      @(negedge clk_i);
      sc += {31'h0, stk};
      bc += {31'h0, btk};
      tc += {31'h0, xck_o ^ p};
      p = xck_o;
    end
    @(posedge clk_i);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h00, 32'h400);
    rd(8'h04, 32'h0);
    rd(8'h0C, 32'h0);
    foreach (tbl[i]) begin
      bus(1'b1, 8'h00, {16'h0, tbl[i][55:40]});
      bus(1'b1, 8'h04, {24'h0, tbl[i][39:32]});
      rd(8'h00, {16'h0, tbl[i][55:40]});
      // Sample counter carries over a mode change, so skip the first bits
      repeat (24) @(posedge clk_i);
      win(tbl[i][31:24]);
      chk(sc, {24'h0, tbl[i][23:16]});
      chk(bc, {24'h0, tbl[i][15:8]});
      chk(tc, {24'h0, tbl[i][7:0]});
      chk({31'h0, xck_oe_n}, {31'h0, tbl[i][7:0] == 8'h00});
    end
    txa <= 1'b1;
    txd <= 1'b1;
    bus(1'b1, 8'h04, 32'h80);
    repeat (3) @(posedge clk_i);
    chk({29'h0, lde, dat_o, dat_oe_n}, 32'h6);
    bus(1'b1, 8'h04, 32'hA0);
    repeat (3) @(posedge clk_i);
    chk({29'h0, lde, dat_o, dat_oe_n}, 32'h5);
    txd <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk({29'h0, lde, dat_o, dat_oe_n}, 32'h4);
    txa <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk({29'h0, lde, dat_o, dat_oe_n}, 32'h0);
    bus(1'b1, 8'h00, 32'h40);
    bus(1'b1, 8'h04, 32'h40);
    halt <= 1'b1;
    repeat (4) @(posedge clk_i);
    win(8'h28);
    chk(sc, 32'h0);
    rd(8'h08, 32'h2);
    bus(1'b1, 8'h04, 32'h0);
    repeat (4) @(posedge clk_i);
    win(8'h20);
    chk(sc, 32'h20);
    halt <= 1'b0;
    bus(1'b1, 8'h04, 32'h1);
    repeat (24) @(posedge clk_i);
    rd(8'h08, 32'hC);
    chk({28'h0, xck_oe_n, mode}, {28'h0, 1'b1, ucg_pkg::UCG_SYNC_SLAVE});
    start <= 1'b1;
    @(posedge clk_i);
    start <= 1'b0;
    win(8'h78);
    chk(bc, 32'hA);
    chk(sc, 32'h14);
    chk(tc, 32'h0);
    results();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    results();
  end
endmodule
`default_nettype wire

// ---- dv/ucg_remote_node.sv ----
// Remote node that clocks the link as synchronous master
`default_nettype none
module ucg_remote_node (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  output logic xck_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_q;
  ////////////////////////////////////////////////////////////////////////////////
  // Ten periods of ten clocks, then the clock stands still low between frames
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 8'h00;
      xck_o <= 1'b0;
    end else if (start_i) begin
      cnt_q <= 8'h64;
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
      if (cnt_q % 8'h05 == 8'h00) begin
        xck_o <= !xck_o;
      end
    end
  end
endmodule
`default_nettype wire

// ---- verilog/ucg_clock_gen.sv ----
// Bit clock generator with Wishbone register slave and transfer clock pin handling
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Contract
// - Two-way transfer clock pin, driven as master
// - Line driver enable output for multidrop transmit
// - Keeps running during debug halt by default
// - Optional stop while processor is debug halted
// - Open-drain select makes data pin wired-AND
// - Five clock generation modes supported
// - Fractional divisor clocks async only; master and SPI use the integer part
// - Async divisor: ten integer, six fraction bits
// - Async rate 64 f over S times divisor
// - Sync rate f over twice integer part
// - Async uses 16 or 8 samples per bit
// - Sync mode uses two samples per bit
// - Sync slave clocks from external transfer pin
// - External clock sampled, below quarter clock rate
// - Everything runs in peripheral clock domain
// - Double speed code doubles async bit rate
module ucg_clock_gen (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic debug_halt_i,
  input wire logic tx_data_i,
  input wire logic tx_active_i,
  input wire logic transfer_clock_pin_i,
  output logic transfer_clock_pin_o,
  output logic transfer_clock_pin_oe_n_o,
  output logic data_pin_o,
  output logic data_pin_oe_n_o,
  output logic line_driver_enable_o,
  output logic sample_tick_o,
  output logic bit_tick_o,
  output ucg_pkg::ucg_mode_t mode_o
);

  typedef struct packed {
    logic [15:0] div;
    logic [1:0] communication_mode_field;
    logic [1:0] rxsel;
    logic master;
    logic od;
    logic halt_en;
    logic tx_en;
    logic xck_s1;
    logic xck_s2;
    logic xck_s3;
    logic [16:0] acc;
    logic [3:0] samp_cnt;
    logic halted;
    ucg_pkg::ucg_mode_t mode;
    logic transfer_clock_pin;
    logic xck_oe_n;
    logic data;
    logic data_oe_n;
    logic drv_en;
    logic samp_tick;
    logic bit_tick;
    logic ack;
    logic [31:0] dat;
  } ucg_state_t;

  ucg_state_t s_q;
  ucg_state_t s_d;

  ////////////////////////////////////////////////////////////////////////////////
  // Decoding shared by the mode register and the tick logic

  function automatic ucg_pkg::ucg_mode_t mode_of(input logic [1:0] communication_mode_field,
                                                 input logic [1:0] rxsel,
                                                 input logic master);
    if (communication_mode_field == ucg_pkg::COMMUNICATION_MODE_FIELD_SPI) begin
      mode_of = ucg_pkg::UCG_SPI_MASTER;
    end else if (communication_mode_field[0]) begin
      mode_of = master ? ucg_pkg::UCG_SYNC_MASTER : ucg_pkg::UCG_SYNC_SLAVE;
    end else if (rxsel == ucg_pkg::RXSEL_DOUBLE) begin
      mode_of = ucg_pkg::UCG_ASYNC_DOUBLE;
    end else begin
      mode_of = ucg_pkg::UCG_ASYNC_NORMAL;
    end
  endfunction

  function automatic logic is_sync(input ucg_pkg::ucg_mode_t m);
    is_sync = (m == ucg_pkg::UCG_SYNC_MASTER) || (m == ucg_pkg::UCG_SYNC_SLAVE) ||
              (m == ucg_pkg::UCG_SPI_MASTER);
  endfunction

  function automatic logic drives_clock(input ucg_pkg::ucg_mode_t m);
    drives_clock = (m == ucg_pkg::UCG_SYNC_MASTER) || (m == ucg_pkg::UCG_SPI_MASTER);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  logic [16:0] eff_div;
  logic [16:0] acc_sum;
  logic [3:0] last_cnt;
  logic halted_now;
  logic samp;
  logic bus_req;
  logic bus_wr;
  logic xck_rise;
  logic xck_edge;

  always_comb begin
    s_d = s_q;
    eff_div = 17'h00000;
    acc_sum = 17'h00000;
    last_cnt = ucg_pkg::SPB_NORMAL_LAST;
    samp = 1'b0;
    s_d.samp_tick = 1'b0;
    s_d.bit_tick = 1'b0;
    s_d.ack = 1'b0;
    s_d.dat = 32'h00000000;

    // External clock passes two flops; edge detect compares the second with a third
    s_d.xck_s1 = transfer_clock_pin_i;
    s_d.xck_s2 = s_q.xck_s1;
    s_d.xck_s3 = s_q.xck_s2;
    xck_rise = s_q.xck_s2 & ~s_q.xck_s3;
    xck_edge = s_q.xck_s2 ^ s_q.xck_s3;
    // A pin faster than a quarter of our clock loses edges here

    // Halt only when software asked for it; otherwise debug halt is ignored
    halted_now = debug_halt_i & s_q.halt_en;
    s_d.halted = halted_now;
    // Mode is registered, so every consumer sees one settled value per cycle
    s_d.mode = mode_of(s_q.communication_mode_field, s_q.rxsel, s_q.master);

    // Sync modes see only the integer part, scaled back to sixty-fourths
    // so one accumulator serves every mode but sync slave
    if (is_sync(s_q.mode)) begin
      eff_div = {1'b0, s_q.div[15:ucg_pkg::FRAC_W], 6'h00};
      last_cnt = ucg_pkg::SPB_SYNC_LAST;
    end else begin
      eff_div = {1'b0, s_q.div};
      if (s_q.mode == ucg_pkg::UCG_ASYNC_DOUBLE) begin
        last_cnt = ucg_pkg::SPB_DOUBLE_LAST;
      end else begin
        last_cnt = ucg_pkg::SPB_NORMAL_LAST;
      end
    end
    // A divisor under one step would never drain the accumulator; clamp to full rate
    // A zero divisor would otherwise tick every cycle while the remainder grows
    if (eff_div < ucg_pkg::ACC_STEP) begin
      eff_div = ucg_pkg::ACC_STEP;
    end

    // Halting freezes accumulator and counter; a bit resumes where it stopped
    if (!halted_now) begin
      if (s_q.mode == ucg_pkg::UCG_SYNC_SLAVE) begin
        s_d.acc = 17'h00000;
        // Both edges count as samples; only the rising edge closes a bit
        samp = xck_edge;
        if (xck_rise) begin
          s_d.bit_tick = 1'b1;
        end
      end else begin
        acc_sum = s_q.acc + ucg_pkg::ACC_STEP;
        if (acc_sum >= eff_div) begin
          samp = 1'b1;
          s_d.acc = acc_sum - eff_div;
        end else begin
          s_d.acc = acc_sum;
        end
        if (samp) begin
          if (s_q.samp_cnt >= last_cnt) begin
            s_d.samp_cnt = 4'h0;
            s_d.bit_tick = 1'b1;
          end else begin
            s_d.samp_cnt = s_q.samp_cnt + 4'h1;
          end
        end
      end
    end
    s_d.samp_tick = samp;

    // Master clock toggles on every sample, giving two samples per bit
    if (drives_clock(s_q.mode)) begin
      s_d.xck_oe_n = 1'b0;
      if (samp) begin
        s_d.transfer_clock_pin = ~s_q.transfer_clock_pin;
      end
    end else begin
      s_d.xck_oe_n = 1'b1;
      s_d.transfer_clock_pin = 1'b0;
    end

    // Wired-AND releases the line for a one instead of driving it
    if (s_q.od) begin
      s_d.data = 1'b0;
      s_d.data_oe_n = ~(s_q.tx_en & ~tx_data_i);
    end else begin
      s_d.data = tx_data_i;
      s_d.data_oe_n = ~s_q.tx_en;
    end
    // Driver enable follows the transmitter one cycle late, like the data pin
    s_d.drv_en = s_q.tx_en & tx_active_i;

    // Wishbone classic: one wait state, ack drops the cycle after
    bus_req = wb_cyc_i & wb_stb_i & ~s_q.ack;
    // A write lands only at the edge where the master sees ack, so a cycle
    // dropped before ack leaves the registers untouched
    bus_wr = wb_cyc_i & wb_stb_i & wb_we_i & s_q.ack;
    if (bus_req) begin
      s_d.ack = 1'b1;
      unique case (wb_adr_i)
        ucg_pkg::DIV_OFS: begin
          s_d.dat = {16'h0000, s_q.div};
        end
        ucg_pkg::CTRL_OFS: begin
          s_d.dat = {24'h000000, s_q.tx_en, s_q.halt_en, s_q.od, s_q.master,
                     s_q.rxsel, s_q.communication_mode_field};
        end
        ucg_pkg::STAT_OFS: begin
          s_d.dat[ucg_pkg::STAT_XCK_BIT] = s_q.xck_s2;
          s_d.dat[ucg_pkg::STAT_HALT_BIT] = s_q.halted;
          s_d.dat[ucg_pkg::STAT_SYNC_BIT] = is_sync(s_q.mode);
          s_d.dat[ucg_pkg::STAT_SLAVE_BIT] = (s_q.mode == ucg_pkg::UCG_SYNC_SLAVE);
        end
        default: begin
          s_d.dat = 32'h00000000;
        end
      endcase
    end

    // New divisor acts from the next edge, the registered mode one edge later; the host keeps the link idle
    // meanwhile, so a short first bit is not guarded against here
    if (bus_wr) begin
      unique case (wb_adr_i)
        ucg_pkg::DIV_OFS: begin
          if (wb_sel_i[0]) begin
            s_d.div[7:0] = wb_dat_i[7:0];
          end
          if (wb_sel_i[1]) begin
            s_d.div[15:8] = wb_dat_i[15:8];
          end
        end
        ucg_pkg::CTRL_OFS: begin
          if (wb_sel_i[0]) begin
            s_d.communication_mode_field = wb_dat_i[ucg_pkg::CTRL_COMMUNICATION_MODE_FIELD_LSB +: 2];
            s_d.rxsel = wb_dat_i[ucg_pkg::CTRL_RXSEL_LSB +: 2];
            s_d.master = wb_dat_i[ucg_pkg::CTRL_MASTER_BIT];
            s_d.od = wb_dat_i[ucg_pkg::CTRL_OD_BIT];
            s_d.halt_en = wb_dat_i[ucg_pkg::CTRL_HALT_BIT];
            s_d.tx_en = wb_dat_i[ucg_pkg::CTRL_TXEN_BIT];
          end
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register
  // Reset releases both pins so nothing fights an outside driver

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.div <= ucg_pkg::DIV_RST;
      s_q.communication_mode_field <= ucg_pkg::CTRL_RST[ucg_pkg::CTRL_COMMUNICATION_MODE_FIELD_LSB +: 2];
      s_q.rxsel <= ucg_pkg::CTRL_RST[ucg_pkg::CTRL_RXSEL_LSB +: 2];
      s_q.master <= ucg_pkg::CTRL_RST[ucg_pkg::CTRL_MASTER_BIT];
      s_q.od <= ucg_pkg::CTRL_RST[ucg_pkg::CTRL_OD_BIT];
      s_q.halt_en <= ucg_pkg::CTRL_RST[ucg_pkg::CTRL_HALT_BIT];
      s_q.tx_en <= ucg_pkg::CTRL_RST[ucg_pkg::CTRL_TXEN_BIT];
      s_q.mode <= ucg_pkg::UCG_ASYNC_NORMAL;
      s_q.xck_oe_n <= 1'b1;
      s_q.data_oe_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_dat_o = s_q.dat;
  assign wb_ack_o = s_q.ack;
  assign transfer_clock_pin_o = s_q.transfer_clock_pin;
  assign transfer_clock_pin_oe_n_o = s_q.xck_oe_n;
  assign data_pin_o = s_q.data;
  assign data_pin_oe_n_o = s_q.data_oe_n;
  assign line_driver_enable_o = s_q.drv_en;
  assign sample_tick_o = s_q.samp_tick;
  assign bit_tick_o = s_q.bit_tick;
  assign mode_o = s_q.mode;

endmodule
`default_nettype wire

// ---- verilog/ucg_pkg.sv ----
// Package of constants and types for the serial transceiver clock generator
`default_nettype none
package ucg_pkg;
  // Register byte offsets
  localparam logic [7:0] DIV_OFS = 8'h00;
  localparam logic [7:0] CTRL_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;
  // Reset values
  localparam logic [15:0] DIV_RST = 16'h0400;
  localparam logic [7:0] CTRL_RST = 8'h00;
  // Divisor layout: integer part above the fractional part
  localparam int DIV_W = 16;
  localparam int FRAC_W = 6;
  localparam logic [16:0] ACC_STEP = 17'h00040;
  // Control field positions
  localparam int CTRL_COMMUNICATION_MODE_FIELD_LSB = 0;
  localparam int CTRL_RXSEL_LSB = 2;
  localparam int CTRL_MASTER_BIT = 4;
  localparam int CTRL_OD_BIT = 5;
  localparam int CTRL_HALT_BIT = 6;
  localparam int CTRL_TXEN_BIT = 7;
  // Field codes
  localparam logic [1:0] COMMUNICATION_MODE_FIELD_SPI = 2'h3;
  localparam logic [1:0] RXSEL_DOUBLE = 2'h1;
  // Status field positions
  localparam int STAT_XCK_BIT = 0;
  localparam int STAT_HALT_BIT = 1;
  localparam int STAT_SYNC_BIT = 2;
  localparam int STAT_SLAVE_BIT = 3;
  // Samples per bit, stored as last count value
  localparam logic [3:0] SPB_NORMAL_LAST = 4'hF;
  localparam logic [3:0] SPB_DOUBLE_LAST = 4'h7;
  localparam logic [3:0] SPB_SYNC_LAST = 4'h1;

  typedef enum logic [2:0] {
    UCG_ASYNC_NORMAL,
    UCG_ASYNC_DOUBLE,
    UCG_SYNC_MASTER,
    UCG_SYNC_SLAVE,
    UCG_SPI_MASTER
  } ucg_mode_t;
endpackage
`default_nettype wire
